// File: rtl/dex_core.sv
// Notes on behaviour
// - operand is 7-bit register, 1-bit destination
// - opcode 000011 computes register minus one
// - decrement updates zero flag only
// - destination 0 to accumulator, 1 to register
// - skip variant skips next when result zero
// - skip variant 001011, no flags, nop cycle
module dex_core
	import dex_pkg::*;
(
	// clock and reset
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	// instruction fetch
	input wire logic [INSN_W-1:0] INSN_IN,
	input wire logic INSN_VALID_IN,
	// register file read port, combinational
	output logic [ADDR_W-1:0] RD_ADDR_OUT,
	input wire logic [DATA_W-1:0] RD_DATA_IN,
	// results
	output logic [ADDR_W-1:0] WR_ADDR_OUT,
	output logic [DATA_W-1:0] WR_DATA_OUT,
	output logic WR_EN_OUT,
	output logic [DATA_W-1:0] ACC_OUT,
	output logic ZERO_OUT,
	output logic ZERO_WE_OUT,
	output logic SKIP_OUT,
	output logic DONE_OUT
);
	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic [5:0] opc;
	logic dest;
	logic is_dec;
	logic is_skip;
	logic live;
	logic [DATA_W-1:0] diff;
	dex_state_type s_q;
	dex_state_type s_d;

	assign opc = INSN_IN[OPC_HI:OPC_LO];
	assign dest = INSN_IN[DEST_BIT];
	assign RD_ADDR_OUT = INSN_IN[ADDR_W-1:0];
	// a squashed slot executes as a nop whatever was fetched
	assign live = INSN_VALID_IN && !s_q.squash;
	assign is_dec = live && (opc == OPC_DEC);
	assign is_skip = live && (opc == OPC_DEC_SKIP);
	assign diff = RD_DATA_IN - ONE;

	// ----------------------------------------
	// execute
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.wr.we = 1'b0;
		s_d.zero_we = 1'b0;
		s_d.skip = 1'b0;
		s_d.done = 1'b0;
		s_d.squash = 1'b0;
		s_d.result = diff;
		s_d.wr.addr = RD_ADDR_OUT;
		s_d.wr.data = diff;
		if (is_dec || is_skip) begin
			s_d.done = 1'b1;
			if (dest == DEST_REG) begin
				s_d.wr.we = 1'b1;
			end else begin
				s_d.acc = diff;
			end
		end
		if (is_dec) begin
			s_d.zero = (diff == '0);
			s_d.zero_we = 1'b1;
		end
		if (is_skip && (diff == '0)) begin
			s_d.skip = 1'b1;
			s_d.squash = 1'b1;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			s_q.acc <= ACC_RESET;
			s_q.zero <= 1'b0;
			s_q.zero_we <= 1'b0;
			s_q.squash <= 1'b0;
			s_q.skip <= 1'b0;
			s_q.wr <= '0;
			s_q.result <= '0;
			s_q.done <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign WR_ADDR_OUT = s_q.wr.addr;
	assign WR_DATA_OUT = s_q.wr.data;
	assign WR_EN_OUT = s_q.wr.we;
	assign ACC_OUT = s_q.acc;
	assign ZERO_OUT = s_q.zero;
	assign ZERO_WE_OUT = s_q.zero_we;
	assign SKIP_OUT = s_q.skip;
	assign DONE_OUT = s_q.done;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence dec_go_s;
		is_dec;
	endsequence
	sequence skip_zero_s;
		is_skip && (diff == '0);
	endsequence
	sequence skip_go_on_s;
		is_skip && (diff != '0);
	endsequence
	sequence dest_reg_s;
		(is_dec || is_skip) && (dest == DEST_REG);
	endsequence
	sequence refused_s;
		INSN_VALID_IN && (opc != OPC_DEC) && (opc != OPC_DEC_SKIP);
	endsequence
	sequence squash_slot_s;
		s_q.squash;
	endsequence
	sequence idle_s;
		!is_dec && !is_skip;
	endsequence

	dec_result_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		is_dec |=> s_q.result == $past(RD_DATA_IN) - ONE)
		else $error("decrement result wrong");
	dec_zero_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		dec_go_s |=> ZERO_WE_OUT && (ZERO_OUT == ($past(RD_DATA_IN) == ONE)))
		else $error("zero flag wrong after decrement");
	dest_reg_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		(is_dec && dest) |=> WR_EN_OUT && WR_ADDR_OUT == $past(RD_ADDR_OUT))
		else $error("register write missing");
	dest_acc_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		(is_dec && !dest) |=> !WR_EN_OUT && ACC_OUT == $past(diff))
		else $error("accumulator not loaded");
	skip_next_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		skip_zero_s |=> SKIP_OUT ##0 (!is_dec && !is_skip))
		else $error("skip did not squash next");
	no_skip_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		(is_skip && diff != '0) |=> !SKIP_OUT)
		else $error("skip taken on nonzero");
	skip_flags_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		is_skip |=> !ZERO_WE_OUT && $stable(ZERO_OUT))
		else $error("skip variant touched flags");
	one_cycle_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		(is_dec || is_skip) |=> DONE_OUT)
		else $error("decrement not done in one cycle");

	// pulses stay low unless an instruction really ran
	refused_op_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		refused_s |=>
		!DONE_OUT && !WR_EN_OUT && !ZERO_WE_OUT && !SKIP_OUT)
		else $error("refused opcode executed");
	done_only_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		idle_s |=>
		!DONE_OUT && !WR_EN_OUT)
		else $error("done without decrement");
	squash_nop_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		squash_slot_s |=>
		!DONE_OUT && !WR_EN_OUT && !ZERO_WE_OUT && !SKIP_OUT)
		else $error("squashed slot executed");
	squash_single_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		squash_slot_s |=>
		!s_q.squash)
		else $error("squash held past one slot");
	acc_hold_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		dest_reg_s |=>
		$stable(ACC_OUT))
		else $error("accumulator changed on register write");
	skip_reg_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		(is_skip && dest == DEST_REG) |=>
		WR_EN_OUT && WR_DATA_OUT == $past(diff))
		else $error("skip variant register write wrong");
	skip_acc_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		(is_skip && dest == DEST_ACC) |=>
		!WR_EN_OUT && ACC_OUT == $past(diff))
		else $error("skip variant accumulator wrong");
	zero_hold_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		!is_dec |=>
		!ZERO_WE_OUT && $stable(ZERO_OUT))
		else $error("zero flag changed without decrement");
	zero_clear_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		(is_dec && RD_DATA_IN != ONE) |=>
		!ZERO_OUT)
		else $error("zero flag set on nonzero result");
	write_data_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		dest_reg_s |=>
		WR_DATA_OUT == $past(RD_DATA_IN) - ONE)
		else $error("write data not decremented");
	wrap_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		(is_dec && RD_DATA_IN == '0) |=>
		s_q.result == '1)
		else $error("decrement did not wrap");
	skip_once_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		SKIP_OUT |->
		DONE_OUT && !ZERO_WE_OUT)
		else $error("skip pulse without its instruction");
	skip_pulse_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		SKIP_OUT |=>
		!SKIP_OUT)
		else $error("skip pulse longer than one cycle");
	skip_resume_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		skip_go_on_s ##1 (INSN_VALID_IN && opc == OPC_DEC) |->
		is_dec)
		else $error("next instruction lost after nonzero skip");
	wr_addr_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		dest_reg_s |=>
		WR_ADDR_OUT == $past(INSN_IN[ADDR_W-1:0]))
		else $error("write address not the operand");
	dest_sel_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
		(is_dec || is_skip) |=>
		WR_EN_OUT == $past(dest))
		else $error("destination bit not obeyed");
endmodule : dex_core

// File: rtl/dex_pkg.sv
package dex_pkg;
	// ----------------------------------------
	// instruction word layout
	// ----------------------------------------
	localparam int INSN_W = 14;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int OPC_HI = 13;
	localparam int OPC_LO = 8;
	localparam int DEST_BIT = 7;
	localparam logic [5:0] OPC_DEC = 6'h03;
	localparam logic [5:0] OPC_DEC_SKIP = 6'h0B;
	localparam logic [INSN_W-1:0] NOP_WORD = 14'h0000;
	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_REG = 1'b1;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [DATA_W-1:0] ONE = 8'h01;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic we;
	} dex_wr_type;

	typedef struct packed {
		logic [DATA_W-1:0] acc;
		logic zero;
		logic zero_we;
		logic squash;
		logic skip;
		dex_wr_type wr;
		logic [DATA_W-1:0] result;
		logic done;
	} dex_state_type;
endpackage : dex_pkg

// File: tb/dex_regfile.sv
module dex_regfile
	import dex_pkg::*;
(
	input wire logic clk_in,
	input wire logic [ADDR_W-1:0] rd_addr_in,
	output logic [DATA_W-1:0] rd_data_out,
	input wire dex_wr_type wr_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [DATA_W-1:0] mem [128];
	initial for (int i = 0; i < 128; i++) mem[i] = i[7:0];
	// forward a pending write so back-to-back reads see it
	assign rd_data_out = (wr_in.we && wr_in.addr == rd_addr_in) ? wr_in.data : mem[rd_addr_in];
	always @(posedge clk_in) if (wr_in.we) mem[wr_in.addr] <= wr_in.data;
endmodule : dex_regfile

// File: tb/decrement_instruction_exec_tb.sv
module decrement_instruction_exec_tb;
	import dex_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK_IN = 0, ARST_N_IN = 0, INSN_VALID_IN = 0;
	logic [INSN_W-1:0] INSN_IN = '0;
	logic [ADDR_W-1:0] RD_ADDR_OUT, WR_ADDR_OUT;
	logic [DATA_W-1:0] RD_DATA_IN, WR_DATA_OUT, ACC_OUT, v;
	logic WR_EN_OUT, ZERO_OUT, ZERO_WE_OUT, SKIP_OUT, DONE_OUT, vld;
	logic [DATA_W-1:0] m [128];
	logic [26:0] q [$];
	logic [26:0] n;
	logic [DATA_W-1:0] acc_m = ACC_RESET;
	bit z_m;
	logic [5:0] opc [3] = '{OPC_DEC, OPC_DEC_SKIP, 6'h0A};
	logic [INSN_W-1:0] w;
	int error_cnt, checked, cyc;
	bit sq;
	always #5 CLK_IN = ~CLK_IN;
	dex_core DUT (
		.CLK_IN(CLK_IN),
		.ARST_N_IN(ARST_N_IN),
		.INSN_IN(INSN_IN),
		.INSN_VALID_IN(INSN_VALID_IN),
		.RD_ADDR_OUT(RD_ADDR_OUT),
		.RD_DATA_IN(RD_DATA_IN),
		.WR_ADDR_OUT(WR_ADDR_OUT),
		.WR_DATA_OUT(WR_DATA_OUT),
		.WR_EN_OUT(WR_EN_OUT),
		.ACC_OUT(ACC_OUT),
		.ZERO_OUT(ZERO_OUT),
		.ZERO_WE_OUT(ZERO_WE_OUT),
		.SKIP_OUT(SKIP_OUT),
		.DONE_OUT(DONE_OUT)
	);
	dex_regfile PM (.clk_in(CLK_IN), .rd_addr_in(RD_ADDR_OUT), .rd_data_out(RD_DATA_IN),
		.wr_in({WR_ADDR_OUT, WR_DATA_OUT, WR_EN_OUT}));
	task automatic chk(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : chk
	task automatic chk_write(input logic [26:0] e);
		chk(WR_EN_OUT === e[19], "write enable");
		if (e[19]) chk({WR_ADDR_OUT, WR_DATA_OUT} === {e[26:20], e[18:11]}, "write address or data");
	endtask : chk_write
	task automatic chk_acc(input logic [26:0] e);
		chk(ACC_OUT === e[8:1], "accumulator");
	endtask : chk_acc
	task automatic chk_zero(input logic [26:0] e);
		chk(ZERO_WE_OUT === e[10] && ZERO_OUT === e[0], "zero flag");
	endtask : chk_zero
	task automatic chk_skip(input logic [26:0] e);
		chk(SKIP_OUT === e[9], "skip");
	endtask : chk_skip
	task automatic summarize;
		$display("checked %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : summarize
	// ----------------------------------------
	// scoreboard
	// ----------------------------------------
	always @(negedge CLK_IN) if (ARST_N_IN) begin
		if (DONE_OUT === 1'b1) begin
			n = q.size() ? q.pop_front() : 'x;
			chk_write(n);
			chk_acc(n);
			chk_zero(n);
			chk_skip(n);
		end else begin
			chk({WR_EN_OUT, ZERO_WE_OUT, SKIP_OUT} === 3'b000, "pulse without execution");
		end
	end
	always @(posedge CLK_IN) if (++cyc > 1000) begin
		error_cnt++;
		summarize();
	end
	initial begin
		for (int i = 0; i < 128; i++) m[i] = i[7:0];
		void'($urandom(74209));
		repeat (12) @(posedge CLK_IN);
		ARST_N_IN <= 1;
		repeat (400) begin
			@(posedge CLK_IN);
			// small register window, so zero results come up
			w = {opc[$urandom % 3], 8'($urandom) & 8'h8F};
			vld = ($urandom % 4) != 0;
			INSN_IN <= w;
			INSN_VALID_IN <= vld;
			if (sq) sq = 0;
			else if (vld && w[13:8] != 6'h0A) begin
				v = m[w[6:0]] - ONE;
				if (w[7]) m[w[6:0]] = v;
				else acc_m = v;
				if (!w[11]) z_m = (v == 8'h00);
				sq = w[11] && v == 8'h00;
				q.push_back({w[6:0], w[7], v, ~w[11], sq, acc_m, z_m});
			end
		end
		@(posedge CLK_IN);
		INSN_VALID_IN <= 0;
		repeat (3) @(posedge CLK_IN);
		chk(q.size() == 0, "notes left unmatched");
		$display("test random_decrement done");
		summarize();
	end
endmodule : decrement_instruction_exec_tb
